// ===== core/flash_frame_device.sv
// flash front end: power-on hold, mode sampling and command framing
`timescale 1ns/10ps
`default_nettype none
module flash_frame_device
    import flash_frame_pkg::*;
#(
    parameter int unsigned WRITE_HOLD_CYC = WRITE_AFTER_POR_CYC
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    flash_link_if.device                link,
    output var  logic                   cmd_valid,
    output var  logic [7:0]             cmd_opcode,
    output var  logic [PAGE_BITS-1:0]   cmd_page,
    output var  logic [OFFSET_BITS-1:0] cmd_offset,
    output var  logic                   cmd_refused,
    output var  logic                   mode3,
    output var  logic                   standby,
    output var  logic                   write_ready
);
    logic [1:0]             cs_sync;
    logic [1:0]             sck_sync;
    logic [1:0]             si_sync;
    logic                   cs_q;
    logic                   sck_q;
    logic                   armed;
    frame_state_t           state;
    logic [2:0]             bit_cnt;
    logic [1:0]             byte_cnt;
    logic [7:0]             shift;
    logic [ADDR_BITS-1:0]   addr;
    logic [2:0]             extra_left;
    logic [22:0]            hold_cnt;
    logic                   cs_fall;
    logic                   sck_rise;
    logic [7:0]             next_byte;
    logic                   byte_done;
    logic [PAGE_BITS-1:0]   page_raw;
    logic [PAGE_BITS-1:0]   page_mask;

    localparam logic [PAGE_BITS-1:0] BLOCK_PAGE_MASK = 12'hFF8;
    localparam logic [PAGE_BITS-1:0] SECT_PAGE_MASK  = 12'hF00;

    // synchronisers: link pins are outside the core clock domain
    // select chain resets low: a select already low at release shows no falling edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync  <= 2'h0;
            sck_sync <= 2'h3;
            si_sync  <= 2'h0;
            cs_q     <= 1'h0;
            sck_q    <= 1'h1;
        end else begin
            cs_sync  <= {cs_sync[0], link.cs_n};
            sck_sync <= {sck_sync[0], link.sck};
            si_sync  <= {si_sync[0], link.si};
            cs_q     <= cs_sync[1];
            sck_q    <= sck_sync[1];
        end
    end

    assign cs_fall   = cs_q && !cs_sync[1];
    assign sck_rise  = !sck_q && sck_sync[1] && !cs_sync[1];
    assign next_byte = {shift[6:0], si_sync[1]};
    assign byte_done = sck_rise && (bit_cnt == 3'h7);

    // block and sector erase ignore their low page bits
    assign page_raw  = (state == ST_ADDR) ? addr[PAGE_LSB+PAGE_BITS-BYTE_BITS-1:PAGE_LSB-BYTE_BITS]
        : addr[PAGE_LSB+PAGE_BITS-1:PAGE_LSB];
    assign page_mask = (cmd_opcode == OP_BLOCK_ERASE) ? BLOCK_PAGE_MASK
        : ((cmd_opcode == OP_SECT_ERASE) ? SECT_PAGE_MASK : '1);

    // output never driven: read data lies outside this front end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.so    <= 1'h0;
            link.so_oe <= 1'h0;
        end else begin
            link.so    <= 1'h0;
            link.so_oe <= 1'h0;
        end
    end

    // mode defaults to 3, then follows the idle clock at each select
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode3 <= 1'h1;
        end else if (cs_fall) begin
            mode3 <= sck_q;
        end
    end

    // write hold-off counter; a saturating count avoids a wrap back to refusal
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt    <= '0;
            write_ready <= 1'h0;
        end else if (hold_cnt < 23'(WRITE_HOLD_CYC)) begin
            hold_cnt    <= hold_cnt + 23'h1;
        end else begin
            write_ready <= 1'h1;
        end
    end

    // a select already low when reset releases is not a command
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed   <= 1'h0;
            standby <= 1'h0;
        end else begin
            standby <= 1'h1;
            if (cs_fall) begin
                armed <= 1'h1;
            end
        end
    end

    // framing state machine
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            bit_cnt    <= 3'h0;
            byte_cnt   <= 2'h0;
            shift      <= 8'h00;
            addr       <= '0;
            extra_left <= EXTRA_NONE;
            cmd_opcode <= 8'h00;
        end else if (cs_sync[1] || !armed) begin
            state   <= ST_IDLE;
            bit_cnt <= 3'h0;
            if (cs_fall) begin
                state <= ST_OPCODE;
            end
        end else begin
            if (sck_rise) begin
                shift   <= next_byte;
                bit_cnt <= bit_cnt + 3'h1;
            end
            unique case (state)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state <= ST_OPCODE;
                    end
                end
                ST_OPCODE: begin
                    if (byte_done) begin
                        cmd_opcode <= next_byte;
                        byte_cnt   <= 2'h0;
                        extra_left <= extra_bytes(next_byte);
                        state      <= opcode_only(next_byte) ? ST_DONE : ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        addr     <= {addr[ADDR_BITS-BYTE_BITS-1:0], next_byte};
                        byte_cnt <= byte_cnt + 2'h1;
                        if (byte_cnt == 2'(ADDR_BYTES - 1)) begin
                            state <= (extra_left == EXTRA_NONE) ? ST_DONE : ST_EXTRA;
                        end
                    end
                end
                ST_EXTRA: begin
                    if (byte_done) begin
                        extra_left <= extra_left - 3'h1;
                        if (extra_left == EXTRA_ONE) begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    state <= ST_DONE;
                end
            endcase
        end
    end

    // one pulse per framed command; unused fields read zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid   <= 1'h0;
            cmd_refused <= 1'h0;
            cmd_page    <= '0;
            cmd_offset  <= '0;
        end else begin
            cmd_valid   <= 1'h0;
            cmd_refused <= 1'h0;
            if (state != ST_DONE && !cs_sync[1] && armed && byte_done && ((state == ST_OPCODE
                    && opcode_only(next_byte)) || (state == ST_ADDR && byte_cnt == 2'(ADDR_BYTES - 1)
                    && extra_left == EXTRA_NONE) || (state == ST_EXTRA && extra_left == EXTRA_ONE))) begin
                if (is_write_op(cmd_opcode) && !write_ready && state != ST_OPCODE) begin
                    cmd_refused <= 1'h1;
                end else begin
                    cmd_valid <= 1'h1;
                end
                if (state == ST_OPCODE) begin
                    cmd_page   <= '0;
                    cmd_offset <= '0;
                end else begin
                    // reserved bits dropped; unused fields masked
                    cmd_page   <= uses_page(cmd_opcode) ? (page_raw & page_mask) : '0;
                    cmd_offset <= uses_offset(cmd_opcode) ? ((state == ST_ADDR)
                        ? {addr[PAGE_LSB-BYTE_BITS-1:0], next_byte}
                        : addr[OFFSET_BITS-1:0]) : '0;
                end
            end
        end
    end
endmodule : flash_frame_device
`default_nettype wire

// ===== core/flash_frame_pkg.sv
// shared constants for the serial flash command framing link
package flash_frame_pkg;
    localparam int unsigned CLK_HZ                 = 20_000_000;
    localparam int unsigned SELECT_AFTER_SUPPLY_US = 70;
    localparam int unsigned WRITE_AFTER_POR_MS     = 20;
    localparam int unsigned SELECT_AFTER_SUPPLY_CYC = (SELECT_AFTER_SUPPLY_US * (CLK_HZ / 1_000_000));
    localparam int unsigned WRITE_AFTER_POR_CYC     = (WRITE_AFTER_POR_MS * (CLK_HZ / 1_000));
    localparam int unsigned BYTE_BITS   = 8;
    localparam int unsigned ADDR_BYTES  = 3;
    localparam int unsigned ADDR_BITS   = 24;
    localparam int unsigned PAGE_BITS   = 12;
    localparam int unsigned OFFSET_BITS = 10;
    localparam int unsigned PAGE_LSB    = 10;
    localparam int unsigned RSVD_BITS   = 2;
    localparam logic [7:0] OP_READ_ARRAY  = 8'h03;
    localparam logic [7:0] OP_FAST_READ   = 8'h0B;
    localparam logic [7:0] OP_MAIN_READ   = 8'hD2;
    localparam logic [7:0] OP_BUF1_FAST   = 8'hD4;
    localparam logic [7:0] OP_BUF2_FAST   = 8'hD6;
    localparam logic [7:0] OP_LEGACY_READ = 8'hE8;
    localparam logic [7:0] OP_READ_ID     = 8'h9F;
    localparam logic [7:0] OP_RESUME      = 8'hB9;
    localparam logic [7:0] OP_WAKE        = 8'hAB;
    localparam logic [7:0] OP_STATUS      = 8'hD7;
    localparam logic [7:0] OP_SEC_READ    = 8'h77;
    localparam logic [7:0] OP_BUF1_WRITE  = 8'h84;
    localparam logic [7:0] OP_BUF2_WRITE  = 8'h87;
    localparam logic [7:0] OP_BUF1_READ   = 8'hD1;
    localparam logic [7:0] OP_BUF2_READ   = 8'hD3;
    localparam logic [7:0] OP_BUF1_PROG   = 8'h83;
    localparam logic [7:0] OP_BUF2_PROG   = 8'h86;
    localparam logic [7:0] OP_BUF1_PROGN  = 8'h88;
    localparam logic [7:0] OP_BUF2_PROGN  = 8'h89;
    localparam logic [7:0] OP_PAGE_ERASE  = 8'h81;
    localparam logic [7:0] OP_VIA_BUF1    = 8'h82;
    localparam logic [7:0] OP_VIA_BUF2    = 8'h85;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OP_SECT_ERASE  = 8'h7C;
    localparam logic [2:0] EXTRA_NONE = 3'h0;
    localparam logic [2:0] EXTRA_ONE  = 3'h1;
    localparam logic [2:0] EXTRA_FOUR = 3'h4;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;

    // trailing don't-care bytes per opcode
    function automatic logic [2:0] extra_bytes(input logic [7:0] op);
        if (op == OP_FAST_READ || op == OP_BUF1_FAST || op == OP_BUF2_FAST) begin
            return EXTRA_ONE;
        end else if (op == OP_MAIN_READ || op == OP_LEGACY_READ) begin
            return EXTRA_FOUR;
        end
        return EXTRA_NONE;
    endfunction

    // opcodes that are framed as a lone byte
    function automatic logic opcode_only(input logic [7:0] op);
        return (op == OP_READ_ID) || (op == OP_RESUME) || (op == OP_WAKE) || (op == OP_STATUS);
    endfunction

    // program and erase class, held off after power-on
    function automatic logic is_write_op(input logic [7:0] op);
        return (op == OP_BUF1_PROG) || (op == OP_BUF2_PROG) || (op == OP_BUF1_PROGN)
            || (op == OP_BUF2_PROGN) || (op == OP_PAGE_ERASE) || (op == OP_VIA_BUF1)
            || (op == OP_VIA_BUF2) || (op == OP_BLOCK_ERASE) || (op == OP_SECT_ERASE);
    endfunction

    // page field used by the opcode
    function automatic logic uses_page(input logic [7:0] op);
        return !(op == OP_SEC_READ || op == OP_BUF1_WRITE || op == OP_BUF2_WRITE
            || op == OP_BUF1_READ || op == OP_BUF2_READ || op == OP_BUF1_FAST || op == OP_BUF2_FAST);
    endfunction

    // offset field used by the opcode
    function automatic logic uses_offset(input logic [7:0] op);
        return (op == OP_READ_ARRAY) || (op == OP_FAST_READ) || (op == OP_VIA_BUF1)
            || (op == OP_VIA_BUF2) || (op == OP_BUF1_WRITE) || (op == OP_BUF2_WRITE)
            || (op == OP_BUF1_READ) || (op == OP_BUF2_READ) || (op == OP_BUF1_FAST)
            || (op == OP_BUF2_FAST) || (op == OP_MAIN_READ) || (op == OP_LEGACY_READ);
    endfunction

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_OPCODE = 3'h1,
        ST_ADDR   = 3'h3,
        ST_EXTRA  = 3'h2,
        ST_DONE   = 3'h6
    } frame_state_t;
endpackage : flash_frame_pkg

// ===== core/flash_link_if.sv
// serial link wires between host controller and flash front end
`timescale 1ns/10ps
`default_nettype none
interface flash_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    modport host (output cs_n, output sck, output si, input so, input so_oe);
    modport device (input cs_n, input sck, input si, output so, output so_oe);
endinterface : flash_link_if
`default_nettype wire

// ===== core/flash_frame_host.sv
// host controller: power-up waits and command framing onto the link
`timescale 1ns/10ps
`default_nettype none
module flash_frame_host
    import flash_frame_pkg::*;
#(
    parameter int unsigned SELECT_WAIT_CYC = SELECT_AFTER_SUPPLY_CYC,
    parameter int unsigned WRITE_WAIT_CYC  = WRITE_AFTER_POR_CYC,
    parameter int unsigned SCK_HALF_CYC    = 4
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    flash_link_if.host                  link,
    input  wire logic                   req_valid,
    input  wire logic [7:0]             req_opcode,
    input  wire logic [PAGE_BITS-1:0]   req_page,
    input  wire logic [OFFSET_BITS-1:0] req_offset,
    output var  logic                   req_ready,
    output var  logic                   req_done
);
    logic [22:0] wait_cnt;
    logic        sel_ok;
    logic        wr_ok;
    logic        busy;
    logic [7:0]  div;
    logic [6:0]  bits_left;
    logic [63:0] frame;
    logic        sck_lvl;
    logic        tick;

    assign tick = (div == 8'(SCK_HALF_CYC - 1));

    // power-up waits; the select wait also gates reads
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= '0;
            sel_ok   <= 1'h0;
            wr_ok    <= 1'h0;
        end else begin
            if (wait_cnt != 23'h7FFFFF) begin
                wait_cnt <= wait_cnt + 23'h1;
            end
            if (wait_cnt >= 23'(SELECT_WAIT_CYC)) begin
                sel_ok <= 1'h1;
            end
            if (wait_cnt >= 23'(WRITE_WAIT_CYC)) begin
                wr_ok <= 1'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'h0;
        end else begin
            // drops on the accepting edge so a held request is not taken twice
            req_ready <= sel_ok && !busy && !(req_valid && req_ready) && (wr_ok || !is_write_op(req_opcode));
        end
    end

    // shifter: clock idles high (mode 3), data changes on falling edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.cs_n <= 1'h1;
            link.sck  <= 1'h1;
            link.si   <= 1'h0;
            busy      <= 1'h0;
            div       <= 8'h00;
            bits_left <= 7'h00;
            frame     <= 64'h0;
            sck_lvl   <= 1'h1;
            req_done  <= 1'h0;
        end else begin
            req_done <= 1'h0;
            if (!busy) begin
                if (req_valid && req_ready) begin
                    busy      <= 1'h1;
                    link.cs_n <= 1'h0;
                    div       <= 8'h00;
                    sck_lvl   <= 1'h1;
                    // two zero reserved bits, page msb first, offset, then dummy bytes
                    frame     <= {req_opcode, 2'h0, req_page, req_offset, 32'h0};
                    link.si   <= req_opcode[7];
                    bits_left <= opcode_only(req_opcode) ? 7'(BYTE_BITS) :
                        7'(BYTE_BITS * (1 + ADDR_BYTES) + BYTE_BITS * extra_bytes(req_opcode));
                end
            end else if (tick) begin
                div <= 8'h00;
                if (bits_left == 7'h00) begin
                    link.cs_n <= 1'h1;
                    busy      <= 1'h0;
                    req_done  <= 1'h1;
                end else if (sck_lvl) begin
                    // data moves half a period ahead of the sampling edge
                    link.sck <= 1'h0;
                    link.si  <= frame[63];
                    sck_lvl  <= 1'h0;
                end else begin
                    link.sck  <= 1'h1;
                    sck_lvl   <= 1'h1;
                    frame     <= {frame[62:0], 1'h0};
                    bits_left <= bits_left - 7'h1;
                end
            end else begin
                div <= div + 8'h01;
            end
        end
    end
endmodule : flash_frame_host
`default_nettype wire

// ===== verif/flash_frame_assertions.sv
// wire-level checks on the host to device serial flash link
`timescale 1ns/10ps
`default_nettype none
module flash_frame_assertions #(
    parameter int unsigned SELECT_WAIT_CYC = 50
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic        sck_q;
    logic [6:0]  nbits;
    logic [15:0] since_rst;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) sck_q <= 1'b1;
        else sck_q <= sck;
    end

    // bits seen in the current select; cleared while deselected
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) nbits <= 7'h00;
        else if (cs_n) nbits <= 7'h00;
        else if (sck && !sck_q) nbits <= nbits + 7'h01;
    end

    // saturates so a long run never wraps back under the wait
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) since_rst <= 16'h0000;
        else if (since_rst != 16'hFFFF) since_rst <= since_rst + 16'h0001;
    end

    AST_SO_FLOAT: assert property (so_oe == 1'b0)
        else $error("device drove its data output");
    AST_SO_QUIET: assert property (so == 1'b0)
        else $error("device data output moved");
    AST_SCK_IDLE: assert property (cs_n |-> sck)
        else $error("link clock not idle high while deselected");
    AST_SEL_FALL: assert property ($fell(cs_n) |-> sck ##1 (!cs_n && sck))
        else $error("select fell without clock idle high");
    AST_SCK_LOW: assert property ($fell(sck) |-> (!sck)[*4] ##1 sck)
        else $error("link clock low phase not four cycles");
    AST_SCK_HIGH: assert property ($rose(sck) && !cs_n |-> sck[*4])
        else $error("link clock high phase under four cycles");
    AST_SEL_WAIT: assert property (!cs_n |-> since_rst >= SELECT_WAIT_CYC)
        else $error("device selected too early after reset");
    AST_FRAME_BITS: assert property ($rose(cs_n) |-> nbits inside {7'h08, 7'h20, 7'h28, 7'h40})
        else $error("frame length is not a legal bit count");
endmodule // flash_frame_assertions
`default_nettype wire

// ===== verif/testbench.sv
// bench: host framing into a device, plus a fault driver on a second device
`timescale 1ns/10ps
`default_nettype none
module testbench
    import flash_frame_pkg::*;
;
    localparam int unsigned SEL_CYC  = 50;
    localparam int unsigned WR_CYC   = 200;
    localparam int unsigned WR_B_CYC = 2000;
    logic                   core_clk, rst_n, rst_b_n, req_valid, req_ready, req_done, sck_q;
    logic [7:0]             req_opcode, opa, opb;
    logic [PAGE_BITS-1:0]   req_page, pga, pgb, pg, pmask;
    logic [OFFSET_BITS-1:0] req_offset, ofa, ofb, of;
    logic                   va, vb, ra, rb, m3a, m3b, sba, sbb, wra, wrb;
    logic [63:0]            shreg;
    logic [15:0]            ent;
    logic [15:0]            tbl [16];
    int                     failures = 0, n_tests = 0, nva = 0, nvb = 0, nra = 0, nrb = 0, nbits = 0;
    int                     nb0, exp_n, n0, k;

    flash_link_if link_a ();
    flash_link_if link_b ();
    flash_frame_host #(.SELECT_WAIT_CYC(SEL_CYC), .WRITE_WAIT_CYC(WR_CYC), .SCK_HALF_CYC(4)) flash_frame_host_i (
        .core_clk(core_clk), .rst_n(rst_n), .link(link_a), .req_valid(req_valid), .req_opcode(req_opcode),
        .req_page(req_page), .req_offset(req_offset), .req_ready(req_ready), .req_done(req_done));
    flash_frame_device #(.WRITE_HOLD_CYC(WR_CYC)) flash_frame_device_i (
        .core_clk(core_clk), .rst_n(rst_n), .link(link_a), .cmd_valid(va), .cmd_opcode(opa), .cmd_page(pga),
        .cmd_offset(ofa), .cmd_refused(ra), .mode3(m3a), .standby(sba), .write_ready(wra));
    // second device faces the bench driver, which breaks the link rules on purpose
    flash_frame_device #(.WRITE_HOLD_CYC(WR_B_CYC)) flash_frame_device_b_i (
        .core_clk(core_clk), .rst_n(rst_b_n), .link(link_b), .cmd_valid(vb), .cmd_opcode(opb), .cmd_page(pgb),
        .cmd_offset(ofb), .cmd_refused(rb), .mode3(m3b), .standby(sbb), .write_ready(wrb));
    flash_frame_assertions #(.SELECT_WAIT_CYC(SEL_CYC)) flash_frame_assertions_i (
        .core_clk(core_clk), .rst_n(rst_n), .cs_n(link_a.cs_n), .sck(link_a.sck), .si(link_a.si),
        .so(link_a.so), .so_oe(link_a.so_oe));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        sck_q <= link_a.sck;
        if (!link_a.cs_n && link_a.sck && !sck_q) begin
            nbits <= nbits + 1;
            shreg <= {shreg[62:0], link_a.si};
        end
        if (va === 1'b1) nva <= nva + 1;
        if (vb === 1'b1) nvb <= nvb + 1;
        if (ra === 1'b1) nra <= nra + 1;
        if (rb === 1'b1) nrb <= nrb + 1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] op, input logic [11:0] p, input logic [9:0] o);
        k = 0;
        req_opcode = op;
        req_page = p;
        req_offset = o;
        req_valid = 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (req_ready !== 1'b1 && k < 1000);
        #1 req_valid = 1'b0;
        chk("req_ready", 1, k < 1000);
        k = 0;
        while (req_done !== 1'b1 && k < 2000) begin
            @(posedge core_clk);
            k++;
        end
        chk("req_done", 1, k < 2000);
        cyc(10);
    endtask

    task automatic bb_bits(input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            link_b.si = v[i];
            link_b.sck = 1'b0;
            cyc(4);
            link_b.sck = 1'b1;
            cyc(4);
        end
    endtask

    // idle level is set before the select falls, since the device samples it there
    task automatic bb_sel(input logic idle);
        link_b.sck = idle;
        cyc(4);
        link_b.cs_n = 1'b0;
        cyc(4);
    endtask

    task automatic bb_end(input logic idle);
        link_b.sck = idle;
        cyc(4);
        link_b.cs_n = 1'b1;
        link_b.si = ~link_b.si;
        cyc(10);
    endtask

    task automatic tally_and_finish();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #2_000_000;
        failures++;
        tally_and_finish();
    end

    initial begin
        {rst_n, rst_b_n, req_valid} = 3'h0;
        {req_opcode, req_page, req_offset} = '0;
        link_b.cs_n = 1'b1;
        link_b.sck = 1'b1;
        link_b.si = 1'b0;
        tbl = '{16'h0303, 16'h0B13, 16'hD243, 16'hE843, 16'hD411, 16'hD611, 16'h9F04,
                16'hB904, 16'hAB04, 16'hD704, 16'h7700, 16'h8401, 16'h8102, 16'h8203, 16'h5002, 16'h7C02};
        cyc(12);
        rst_n = 1'b1;
        cyc(2);
        chk("mode3", 1, m3a);
        chk("standby", 1, sba);
        chk("write_ready", 0, wra);
        for (int i = 0; i < 16; i++) begin
            pg = i[0] ? 12'hFFF : 12'h801;
            of = i[0] ? 10'h3FF : 10'h200;
            ent = tbl[i];
            exp_n = ent[2] ? 8 : 32 + 8 * ent[7:4];
            n0 = nva;
            nb0 = nbits;
            // block erase keeps nine page bits, sector erase four
            pmask = (ent[15:8] == 8'h50) ? 12'hFF8 : ((ent[15:8] == 8'h7C) ? 12'hF00 : 12'hFFF);
            send(ent[15:8], pg, of);
            chk("bit count", exp_n, nbits - nb0);
            chk("wire opcode", ent[15:8], 8'(shreg >> (exp_n - 8)));
            if (!ent[2]) chk("wire address", {2'b00, pg, of}, 24'(shreg >> (exp_n - 32)));
            chk("cmd count", n0 + 1, nva);
            chk("cmd_opcode", ent[15:8], opa);
            chk("cmd_page", ent[1] ? (pg & pmask) : 12'h000, pga);
            chk("cmd_offset", ent[0] ? of : 10'h000, ofa);
        end
        chk("write_ready", 1, wra);
        chk("refused", 0, nra);
        chk("so_oe", 0, link_a.so_oe);
        $display("test host frames done");
        bb_sel(1'b1);
        bb_bits(64'h0000_0000_0301_2345, 32);
        chk("frame in reset", 0, nvb);
        rst_b_n = 1'b1;
        cyc(2);
        chk("mode3 b", 1, m3b);
        chk("standby b", 1, sbb);
        bb_bits(64'h0000_0000_0301_2345, 32);
        chk("no select edge", 0, nvb);
        bb_end(1'b1);
        bb_sel(1'b0);
        chk("mode0 b", 0, m3b);
        bb_bits({32'h0, 8'h84, 2'b11, 12'hFFF, 10'h155}, 32);
        bb_end(1'b0);
        chk("cmd b", 1, nvb);
        chk("page b", 0, pgb);
        chk("offset b", 10'h155, ofb);
        bb_sel(1'b1);
        chk("mode3 again", 1, m3b);
        chk("write_ready b", 0, wrb);
        bb_bits(64'h0000_0000_813F_FC00, 32);
        bb_end(1'b1);
        chk("refused b", 1, nrb);
        chk("no cmd on refusal", 1, nvb);
        bb_sel(1'b1);
        bb_bits(64'h0000_0000_0000_0312, 16);
        bb_end(1'b1);
        chk("aborted frame", 1, nvb);
        k = 0;
        while (wrb !== 1'b1 && k < 3000) begin
            cyc(1);
            k++;
        end
        chk("write_ready b late", 1, wrb);
        bb_sel(1'b1);
        bb_bits(64'h0000_0000_8100_0400, 32);
        bb_end(1'b1);
        chk("write accepted b", 2, nvb);
        chk("page write b", 12'h001, pgb);
        chk("so_oe b", 0, link_b.so_oe);
        $display("test fault driver done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
